//--- timer_pkg.sv
// Purpose: Shared constants and types for the event count / pulse measure timer.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
package timer_pkg;
    localparam int CNT_W = 16;
    localparam logic [11:0] OFF_TIMER = 12'h000;
    localparam logic [11:0] OFF_MODE = 12'h004;
    localparam logic [11:0] OFF_START = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    localparam logic [11:0] OFF_MASK = 12'h010;
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_MEASURE = 2'h2;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] PRESC_DIV8 = 2'h1;
    localparam logic [1:0] PRESC_DIV32 = 2'h2;
    localparam int DIV8_W = 3;
    localparam int MODE_LSB = 0;
    localparam int EDGE_LSB = 2;
    localparam int PRESC_LSB = 4;
    localparam int WIDTH_BIT = 6;
    localparam int OVF_BIT = 7;
    localparam int IRQ_UNDER = 0;
    localparam int IRQ_EDGE = 1;
    localparam int IRQ_OVF = 2;
    localparam int IRQ_W = 3;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] edge_sel;
        logic [1:0] presc_sel;
        logic width_meas;
    } timer_cfg_t;

    typedef struct packed {
        logic under;
        logic meas_edge;
        logic ovf;
    } timer_evt_t;
endpackage

//--- edge_detect.sv
// Purpose: Detects rising and falling edges of the synchronous count input.
// Assumes: Input already synchronous to pclk.
// Notes: A single pipeline flop supplies the previous level.
`timescale 1ns/1ps
module edge_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sig_in,
    output logic rise,
    output logic fall
);
    logic prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sig_in;
        end
    end

    assign rise = sig_in & ~prev_reg;
    assign fall = ~sig_in & prev_reg;
endmodule

//--- event_count_pulse_measure_timer.sv
// Purpose: One 16-bit timer channel: timer, event counter and pulse measurement.
// Assumes: APB slave, 32-bit data; count input synchronous to pclk.
// Notes: Interrupt status clears on read; mask gates the irq output.
// Functional notes
// - Event mode counts rising, falling or both edges.
// - Event mode counts down, underflow irq, reloads.
// - One underflow per n plus one edges.
// - Start flag one runs, zero stops counting.
// - Event mode read returns live count.
// - Write while stopped loads reload and counter.
// - Write while running loads reload only.
// - Pinless channel is internal timer only.
// - Measure counts up; edge captures, restarts zero.
// - Measure irq per edge except first.
// - Overflow raises irq and sets overflow flag.
// - Mode write while running clears overflow flag.
// - Measure read returns reload register result.
// - Measure mode ignores timer register writes.
// - Mode register low two bits select mode.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module event_count_pulse_measure_timer #(
    parameter bit HAS_INPUT_PIN = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_input_pin,
    output logic irq
);
    localparam int W = timer_pkg::CNT_W;

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic wr_en;
    logic rd_en;
    logic rd_setup;
    logic hit;
    logic [31:0] prdata_reg;

    function automatic logic sel(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    assign hit = sel(paddr, timer_pkg::OFF_TIMER) | sel(paddr, timer_pkg::OFF_MODE)
        | sel(paddr, timer_pkg::OFF_START) | sel(paddr, timer_pkg::OFF_STATUS)
        | sel(paddr, timer_pkg::OFF_MASK);
    // Every register answers at once, so pready stays high; an unmapped
    // address is refused with pslverr and changes nothing.
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign wr_en = psel & penable & pwrite & hit;
    assign rd_en = psel & penable & ~pwrite & hit;
    assign rd_setup = psel & ~penable & ~pwrite & hit;

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [7:0] mode_reg;
    logic start_reg;
    logic [timer_pkg::IRQ_W-1:0] mask_reg;
    timer_pkg::timer_cfg_t cfg;
    logic [1:0] eff_mode;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= timer_pkg::MODE_RESET;
        end else if (wr_en && sel(paddr, timer_pkg::OFF_MODE)) begin
            mode_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_reg <= 1'b0;
        end else if (wr_en && sel(paddr, timer_pkg::OFF_START)) begin
            start_reg <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= '0;
        end else if (wr_en && sel(paddr, timer_pkg::OFF_MASK)) begin
            mask_reg <= pwdata[timer_pkg::IRQ_W-1:0];
        end
    end

    assign cfg.mode = mode_reg[timer_pkg::MODE_LSB +: 2];
    assign cfg.edge_sel = mode_reg[timer_pkg::EDGE_LSB +: 2];
    assign cfg.presc_sel = mode_reg[timer_pkg::PRESC_LSB +: 2];
    assign cfg.width_meas = mode_reg[timer_pkg::WIDTH_BIT];

    // A channel without a pin falls back to plain timer mode, whatever is written.
    assign eff_mode = (HAS_INPUT_PIN || cfg.mode == timer_pkg::MODE_TIMER)
        ? cfg.mode : timer_pkg::MODE_TIMER;

    // ************************************************************
    // Edge and prescaler sources
    // ************************************************************
    logic pin_gated;
    logic in_rise;
    logic in_fall;
    logic ev_edge;
    logic meas_edge;
    logic [4:0] presc_reg;
    logic tick;

    // A pinless channel sees a quiet low input, so no edge can ever reach it.
    assign pin_gated = HAS_INPUT_PIN ? count_input_pin : 1'b0;

    edge_detect u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .sig_in(pin_gated),
        .rise(in_rise),
        .fall(in_fall)
    );

    function automatic logic pick_edge(input logic [1:0] s, input logic r, input logic f);
        case (s)
            timer_pkg::EDGE_RISE: pick_edge = r;
            timer_pkg::EDGE_BOTH: pick_edge = r | f;
            default: pick_edge = f;
        endcase
    endfunction

    assign ev_edge = pick_edge(cfg.edge_sel, in_rise, in_fall);
    // Width measurement restarts on every transition; period only on the chosen one.
    assign meas_edge = cfg.width_meas ? (in_rise | in_fall)
        : pick_edge(cfg.edge_sel, in_rise, in_fall);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_reg <= '0;
        end else if (!start_reg) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 5'h01;
        end
    end

    // Divide by 1, 8 or 32 from the free prescaler. It restarts with the
    // start flag, so the first divided tick comes a full period after start.
    always_comb begin
        case (cfg.presc_sel)
            timer_pkg::PRESC_DIV8: tick = &presc_reg[timer_pkg::DIV8_W-1:0];
            timer_pkg::PRESC_DIV32: tick = &presc_reg;
            default: tick = 1'b1;
        endcase
    end

    // ************************************************************
    // Counter, reload and measurement state
    // ************************************************************
    // ST_FIRST waits for the edge that opens the first interval; the capture
    // made at that edge is not a result and raises no request.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FIRST = 3'b010,
        ST_MEAS = 3'b100
    } meas_state_t;

    meas_state_t state_reg;
    logic [W-1:0] cnt_reg;
    logic [W-1:0] reload_reg;
    logic ovf_reg;
    logic tmr_wr;
    logic is_meas;
    logic cnt_step;
    timer_pkg::timer_evt_t evt;

    assign tmr_wr = wr_en && sel(paddr, timer_pkg::OFF_TIMER);
    assign is_meas = eff_mode == timer_pkg::MODE_MEASURE;
    assign cnt_step = (eff_mode == timer_pkg::MODE_EVENT) ? ev_edge : tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // An edge in the first running cycle is already the first one.
                    if (start_reg && is_meas && meas_edge) begin
                        state_reg <= ST_MEAS;
                    end else if (start_reg && is_meas) begin
                        state_reg <= ST_FIRST;
                    end
                end
                ST_FIRST: begin
                    if (!start_reg || !is_meas) begin
                        state_reg <= ST_IDLE;
                    end else if (meas_edge) begin
                        state_reg <= ST_MEAS;
                    end
                end
                ST_MEAS: begin
                    if (!start_reg || !is_meas) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Counter runs only while the start flag is set. In measurement mode the
    // capture edge wins over the tick, so each interval starts from zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= timer_pkg::CNT_ZERO;
        end else if (is_meas) begin
            if (start_reg) begin
                if (meas_edge) begin
                    cnt_reg <= timer_pkg::CNT_ZERO;
                end else if (tick) begin
                    cnt_reg <= cnt_reg + timer_pkg::CNT_ONE;
                end
            end
        end else if (tmr_wr && !start_reg) begin
            cnt_reg <= pwdata[W-1:0];
        end else if (start_reg && cnt_step) begin
            if (cnt_reg == timer_pkg::CNT_ZERO) begin
                cnt_reg <= reload_reg;
            end else begin
                cnt_reg <= cnt_reg - timer_pkg::CNT_ONE;
            end
        end
    end

    // Reload follows every write outside measurement mode; the counter only
    // takes it while stopped or at an underflow.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_reg <= timer_pkg::CNT_ZERO;
        end else if (is_meas) begin
            if (start_reg && meas_edge) begin
                reload_reg <= cnt_reg;
            end
        end else if (tmr_wr) begin
            reload_reg <= pwdata[W-1:0];
        end
    end
    // Writes to the timer register in measurement mode fall through both
    // processes above untouched.

    // Events are one-cycle strobes into the sticky status bits.
    assign evt.under = !is_meas && start_reg && cnt_step
        && cnt_reg == timer_pkg::CNT_ZERO;
    assign evt.meas_edge = is_meas && start_reg && meas_edge
        && state_reg == ST_MEAS;
    assign evt.ovf = is_meas && start_reg && tick && !meas_edge
        && cnt_reg == timer_pkg::CNT_MAX;

    // An overflow in the same cycle as a clearing mode write still sets the flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_reg <= 1'b0;
        end else if (evt.ovf) begin
            ovf_reg <= 1'b1;
        end else if (wr_en && sel(paddr, timer_pkg::OFF_MODE) && start_reg) begin
            ovf_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Interrupt status
    // ************************************************************
    logic [timer_pkg::IRQ_W-1:0] status_reg;
    logic [timer_pkg::IRQ_W-1:0] status_next;
    logic [timer_pkg::IRQ_W-1:0] evt_vec;
    logic status_rd;

    assign evt_vec = {evt.ovf, evt.meas_edge, evt.under};
    assign status_rd = rd_en && sel(paddr, timer_pkg::OFF_STATUS);

    // The word was taken at the end of the setup cycle, so a read clears only
    // the bits it reported; a later event stays pending and new events win.
    assign status_next = status_rd
        ? ((status_reg & ~prdata_reg[timer_pkg::IRQ_W-1:0]) | evt_vec)
        : (status_reg | evt_vec);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_next & mask_reg);
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    logic [31:0] rd_next;

    // Measurement mode shows the last captured result; the value is only
    // meaningful after the second effective edge.
    always_comb begin
        rd_next = '0;
        if (rd_setup) begin
            case (paddr)
                timer_pkg::OFF_TIMER: rd_next[W-1:0] = is_meas ? reload_reg
                    : cnt_reg;
                timer_pkg::OFF_MODE: begin
                    rd_next[timer_pkg::OVF_BIT-1:0] = mode_reg[timer_pkg::OVF_BIT-1:0];
                    rd_next[timer_pkg::OVF_BIT] = ovf_reg;
                end
                timer_pkg::OFF_START: rd_next[0] = start_reg;
                timer_pkg::OFF_STATUS: rd_next[timer_pkg::IRQ_W-1:0] = status_reg;
                timer_pkg::OFF_MASK: rd_next[timer_pkg::IRQ_W-1:0] = mask_reg;
                default: rd_next = '0;
            endcase
        end
    end

    // The word is taken at the end of the setup cycle and driven from a flop
    // through the access cycle, so no wait state is needed; between transfers
    // rd_next is zero and the bus reads zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else begin
            prdata_reg <= rd_next;
        end
    end

    assign prdata = prdata_reg;
endmodule

//--- timer_chk_props.sv
// Purpose: Port checker for the timer channel.
// Assumes: Zero wait APB; shadow copies follow the mode and start writes.
// Notes: In measure mode the held value is dropped whenever the pin moves, so captures never fire it.
`timescale 1ns/1ps
module timer_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic count_input_pin,
    input wire logic irq
);
    logic acc, wr, rd, tmr, moved;
    logic [1:0] mode_reg;
    logic start_reg, held_reg, p1_reg, p2_reg, p3_reg;
    logic [15:0] val_reg;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign tmr = paddr == timer_pkg::OFF_TIMER;
    assign moved = count_input_pin != p1_reg || p1_reg != p2_reg || p2_reg != p3_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mode_reg, start_reg, held_reg, p1_reg, p2_reg, p3_reg} <= 7'h00;
            val_reg <= 16'h0000;
        end else begin
            {p1_reg, p2_reg, p3_reg} <= {count_input_pin, p1_reg, p2_reg};
            if (wr && paddr == timer_pkg::OFF_MODE) mode_reg <= pwdata[1:0];
            if (wr && paddr == timer_pkg::OFF_START) start_reg <= pwdata[0];
            if (wr && (paddr == timer_pkg::OFF_MODE || paddr == timer_pkg::OFF_START)) begin
                held_reg <= 1'b0;
            end else if (mode_reg == timer_pkg::MODE_MEASURE && moved) begin
                held_reg <= 1'b0;
            end else if (mode_reg == timer_pkg::MODE_EVENT && !start_reg && wr && tmr) begin
                held_reg <= 1'b1;
                val_reg <= pwdata[15:0];
            end else if (mode_reg == timer_pkg::MODE_MEASURE && rd && tmr && !held_reg) begin
                held_reg <= 1'b1;
                val_reg <= prdata[15:0];
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_idle; !acc |-> prdata == 32'h0 && !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("read data or error outside access");
    property p_unmapped; acc && paddr > timer_pkg::OFF_MASK |-> pslverr && pready; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_evt_load; held_reg && mode_reg == timer_pkg::MODE_EVENT && rd && tmr
        |-> prdata[15:0] == val_reg; endproperty
    a_evt_load: assert property (p_evt_load) else $error("stopped counter value lost");
    property p_meas_ign; held_reg && mode_reg == timer_pkg::MODE_MEASURE && rd && tmr
        |-> prdata[15:0] == val_reg; endproperty
    a_meas_ign: assert property (p_meas_ign) else $error("result changed without edge");
    property p_mode_rd; rd && paddr == timer_pkg::OFF_MODE |-> prdata[1:0] == mode_reg; endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode field mismatch");
    property p_start_rd; rd && paddr == timer_pkg::OFF_START |-> prdata[0] == start_reg; endproperty
    a_start_rd: assert property (p_start_rd) else $error("start flag mismatch");
    property p_mask_irq; wr && paddr == timer_pkg::OFF_MASK && pwdata[2:0] == 3'h0 |-> ##2 !irq;
    endproperty
    a_mask_irq: assert property (p_mask_irq) else $error("irq with all masked");
    property p_ovf_clr; wr && paddr == timer_pkg::OFF_MODE && start_reg ##3
        rd && paddr == timer_pkg::OFF_MODE |-> !prdata[timer_pkg::OVF_BIT]; endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag not cleared");
endmodule
bind event_count_pulse_measure_timer timer_chk timer_chk_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .count_input_pin, .irq);

//--- pulse_source.sv
// Purpose: Square wave source standing in for the external measured signal.
// Assumes: Driven level input; no release state.
// Notes: Holds its level while stopped, so no stray edges appear between bursts.
`timescale 1ns/1ps
module pulse_source (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [7:0] half,
    output logic pin
);
    logic [7:0] cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            pin <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= (cnt_reg + 8'h01 >= half) ? 8'h00 : cnt_reg + 8'h01;
            if (cnt_reg + 8'h01 >= half) pin <= !pin;
        end
    end
endmodule

//--- event_count_pulse_measure_timer_test.sv
// Purpose: Self-checking bench for the timer channel.
// Assumes: Zero wait APB; pulse source toggles every half cycles.
// Notes: Edges are counted here from the pin itself.
`timescale 1ns/1ps
module event_count_pulse_measure_timer_test;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic pready, pslverr, err, pin, irq, run = 1'b0, pin_q = 1'b0, wm = 1'b0;
    logic [7:0] half = 8'h04;
    int fail_count = 0, samples_checked = 0, seed = 63392, rises = 0, falls = 0, n, r, e, h;
    always #10 pclk = ~pclk;
    event_count_pulse_measure_timer event_count_pulse_measure_timer_inst (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .count_input_pin(pin), .irq);
    pulse_source pulse_source_inst (.pclk, .presetn, .run, .half, .pin);
    always @(posedge pclk) begin
        pin_q <= pin;
        if (pin && !pin_q) rises++;
        if (!pin && pin_q) falls++;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic edges(input int k);
        for (int i = 0; i < 3000 && (wm ? rises + falls : rises) < k; i++) @(posedge pclk);
        if ((wm ? rises + falls : rises) < k) begin
            fail_count++;
            $display("[FAIL] edge wait expected %0d seen %0d", k, wm ? rises + falls : rises);
        end
    endtask
    // Reference down counter: zero reloads instead of decrementing.
    function automatic int evt_cnt(input int n, input int r, input int e);
        int c;
        c = n;
        for (int i = 0; i < e; i++) c = (c == 0) ? r : c - 1;
        return c;
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        fail_count++;
        results();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        for (int s = 0; s < 3; s++) begin
            n = 2 + ($random(seed) & 7);
            r = 1 + ($random(seed) & 7);
            h = 2 + ($random(seed) & 3);
            apb(1'b1, timer_pkg::OFF_MODE, {28'h0, 2'(s), timer_pkg::MODE_EVENT});
            apb(1'b1, timer_pkg::OFF_TIMER, 32'(n));
            apb(1'b0, timer_pkg::OFF_TIMER, 32'h0);
            chk("stopped load", 32'(n), rd);
            apb(1'b1, timer_pkg::OFF_MASK, 32'h1);
            apb(1'b1, timer_pkg::OFF_START, 32'h1);
            apb(1'b1, timer_pkg::OFF_TIMER, 32'(r));
            apb(1'b0, timer_pkg::OFF_STATUS, 32'h0);
            rises = 0;
            falls = 0;
            half <= 8'(h);
            run <= 1'b1;
            repeat (20 + ($random(seed) & 31)) @(posedge pclk);
            run <= 1'b0;
            repeat (4) @(posedge pclk);
            e = s == 0 ? falls : s == 1 ? rises : rises + falls;
            chk("irq level", 32'(e > n), {31'h0, irq});
            apb(1'b0, timer_pkg::OFF_TIMER, 32'h0);
            chk("live count", 32'(evt_cnt(n, r, e)), rd);
            apb(1'b0, timer_pkg::OFF_STATUS, 32'h0);
            chk("underflow", 32'(e > n), {31'h0, rd[timer_pkg::IRQ_UNDER]});
            apb(1'b1, timer_pkg::OFF_START, 32'h0);
            run <= 1'b1;
            repeat (12) @(posedge pclk);
            run <= 1'b0;
            repeat (4) @(posedge pclk);
            apb(1'b0, timer_pkg::OFF_TIMER, 32'h0);
            chk("stopped count", 32'(evt_cnt(n, r, e)), rd);
        end
        // Internal timer mode on the divide-by-8 source: r ticks in 8*r running edges.
        n = $random(seed) & 3;
        r = 1 + ($random(seed) & 3);
        apb(1'b1, timer_pkg::OFF_MODE, {26'h0, timer_pkg::PRESC_DIV8, 2'h0,
            timer_pkg::MODE_TIMER});
        apb(1'b1, timer_pkg::OFF_TIMER, 32'(n));
        apb(1'b1, timer_pkg::OFF_START, 32'h1);
        repeat (8 * r - 3) @(posedge pclk);
        apb(1'b1, timer_pkg::OFF_START, 32'h0);
        apb(1'b0, timer_pkg::OFF_TIMER, 32'h0);
        chk("prescaled count", 32'(evt_cnt(n, n, r)), rd);
        for (int w = 0; w < 2; w++) begin
            h = 4 + ($random(seed) & 7);
            wm = 1'(w);
            apb(1'b1, timer_pkg::OFF_MODE, {25'h0, 1'(w), 2'h0, timer_pkg::EDGE_RISE,
                timer_pkg::MODE_MEASURE});
            apb(1'b0, timer_pkg::OFF_TIMER, 32'h0);
            v = rd;
            apb(1'b1, timer_pkg::OFF_TIMER, 32'h1234 ^ v);
            apb(1'b0, timer_pkg::OFF_TIMER, 32'h0);
            chk("write ignored", v, rd);
            apb(1'b1, timer_pkg::OFF_MASK, 32'h2);
            apb(1'b1, timer_pkg::OFF_START, 32'h1);
            apb(1'b0, timer_pkg::OFF_STATUS, 32'h0);
            rises = 0;
            falls = 0;
            half <= 8'(h);
            run <= 1'b1;
            edges(1);
            repeat (3) @(posedge pclk);
            chk("first edge quiet", 32'h0, {31'h0, irq});
            edges(3);
            run <= 1'b0;
            repeat (4) @(posedge pclk);
            // The result is only trusted once the second effective edge has passed.
            apb(1'b0, timer_pkg::OFF_TIMER, 32'h0);
            chk("measured", 32'(w ? h - 1 : 2 * h - 1), rd);
            chk("edge irq", 32'h1, {31'h0, irq});
            apb(1'b1, timer_pkg::OFF_START, 32'h0);
        end
        apb(1'b1, timer_pkg::OFF_MODE, 32'h2);
        apb(1'b1, timer_pkg::OFF_MASK, 32'h4);
        apb(1'b1, timer_pkg::OFF_START, 32'h1);
        repeat (65600) @(posedge pclk);
        chk("overflow irq", 32'h1, {31'h0, irq});
        apb(1'b0, timer_pkg::OFF_MODE, 32'h0);
        chk("overflow flag", 32'h1, {31'h0, rd[timer_pkg::OVF_BIT]});
        apb(1'b1, timer_pkg::OFF_MODE, 32'h2);
        apb(1'b0, timer_pkg::OFF_MODE, 32'h0);
        chk("flag cleared", 32'h0, {31'h0, rd[timer_pkg::OVF_BIT]});
        apb(1'b0, timer_pkg::OFF_STATUS, 32'h0);
        chk("overflow status", 32'h1, {31'h0, rd[timer_pkg::IRQ_OVF]});
        apb(1'b1, timer_pkg::OFF_MASK, 32'h0);
        results();
    end
endmodule
